// ==== psfgp_pkg.sv ====
package psfgp_pkg;

  // ----------------------------------------
  // Register indices (byte address = 4 x index)
  // ----------------------------------------
  localparam logic [9:0] FIRC_IDX  = 10'h00D;
  localparam logic [9:0] PROFC_IDX = 10'h00B;
  localparam logic [9:0] MAINC_IDX = 10'h00C;
  localparam logic [9:0] FMT_IDX   = 10'h017;
  localparam logic [9:0] CADDR_IDX = 10'h020;
  localparam logic [9:0] CDATA_IDX = 10'h021;
  localparam logic [9:0] PADDR_IDX = 10'h022;
  localparam logic [9:0] PDATA_IDX = 10'h023;
  localparam logic [9:0] STAT_IDX  = 10'h024;

  // ----------------------------------------
  // Reset values and field positions
  // ----------------------------------------
  localparam logic [15:0] CTRL_RST  = 16'h0000;
  localparam logic [9:0]  CADDR_RST = 10'h000;
  localparam logic [6:0]  PADDR_RST = 7'h00;
  localparam int IP_LSB     = 0;
  localparam int SPAN_LSB   = 4;
  localparam int BANK_BIT   = 8;
  localparam int PEN_BIT    = 15;
  localparam int PLEN_LSB   = 0;
  localparam int FAST_BIT   = 7;
  localparam int BYP_BIT    = 8;
  localparam int HOLD_BIT   = 14;
  localparam int FLOAT_BIT  = 12;
  localparam int CSEL_I_BIT = 8;
  localparam int CSEL_Q_BIT = 9;

  // ----------------------------------------
  // Encodings and constants
  // ----------------------------------------
  localparam logic [1:0]  IP_4        = 2'h0;
  localparam logic [1:0]  IP_8        = 2'h1;
  localparam logic [7:0]  BANK1_SMALL = 8'h08;
  localparam logic [7:0]  BANK1_LARGE = 8'h80;
  localparam logic [11:0] GAIN_UNITY  = 12'h800;
  localparam int          GAIN_FRAC   = 11;
  localparam int          ALIGN_DEPTH = 4;
  localparam int          ALIGN_CUT   = 2;

  typedef struct packed {
    logic signed [15:0] i;
    logic signed [15:0] q;
  } psfgp_iq_t;

  typedef struct packed {
    logic signed [19:0] i;
    logic signed [19:0] q;
  } psfgp_out_t;

  typedef enum logic [1:0] {
    PSFGP_IDLE,
    PSFGP_RUN,
    PSFGP_OUT
  } psfgp_state_t;

endpackage : psfgp_pkg

// ==== psfgp_mac.sv ====
`timescale 1ns/1ps
`default_nettype none
module psfgp_mac (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               coef_we,
  input  wire logic [7:0]         coef_waddr,
  input  wire logic [23:0]        coef_wdata,
  input  wire logic [7:0]         coef_raddr,
  input  wire logic               float_mode,
  input  wire logic               shift_en,
  input  wire logic signed [15:0] shift_data,
  input  wire logic [3:0]         tap_idx,
  input  wire logic               mac_en,
  input  wire logic               mac_first,
  input  wire logic               mac_last,
  output logic signed [19:0]      res_q
);

  logic [23:0]        mem_q [256];
  logic signed [15:0] dl_q  [16];
  logic signed [39:0] acc_q;
  logic [23:0]        cw;
  logic signed [19:0] cnorm;
  logic signed [35:0] prod;
  logic signed [39:0] sum;

  always_ff @(posedge clk) begin
    if (coef_we) begin
      mem_q[coef_waddr] <= coef_wdata;
    end
  end

  // ----------------------------------------
  // Data delay line, newest sample at 0
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dl_q[0] <= 16'sh0000;
    end else if (shift_en) begin
      dl_q[0] <= shift_data;
    end
  end

  for (genvar g = 1; g < 16; g++) begin : g_dl
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        dl_q[g] <= 16'sh0000;
      end else if (shift_en) begin
        dl_q[g] <= dl_q[g-1];
      end
    end
  end

  // Both formats end up as a 20-bit fraction
  assign cw    = mem_q[coef_raddr];
  assign cnorm = float_mode ? ($signed(cw[23:4]) >>> cw[3:0])
                            : $signed({cw[15:0], 4'h0});
  assign prod  = dl_q[tap_idx] * cnorm;
  assign sum   = (mac_first ? 40'sh0000000000 : acc_q) + 40'(prod);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_q <= 40'sh0000000000;
      res_q <= 20'sh00000;
    end else if (mac_en) begin
      acc_q <= sum;
      if (mac_last) begin
        // Clip to full scale beyond +/-1.0
        if (sum[39:34] == {6{sum[39]}}) begin
          res_q <= sum[34:15];
        end else begin
          res_q <= sum[39] ? 20'sh80000 : 20'sh7FFFF;
        end
      end
    end
  end

endmodule : psfgp_mac
`default_nettype wire

// ==== psfgp_top.sv ====
// Functional notes
// - Phase count 4, 8 or 16 comes from filter control bits 1:0.
// - Tap span minus one is held in filter control bits 7:4.
// - One clock per tap per phase; phase count outputs per sample.
// - Filter runs at phase count times sample rate from NCO phase ticks.
// - Separate I and Q coefficient memories, written together or alone.
// - Control bit 8 picks bank; start 0, else 8 or 128 for 16 phases.
// - Coefficient for phase p, tap k sits at bank start plus p plus 16k.
// - Phases computed in ascending order from zero after each sample.
// - Float mode: 20-bit mantissa scaled by two to minus 4-bit exponent.
// - Two's complement default; float when format word bit 12 set.
// - Filter output clips to full scale beyond plus or minus one.
// - Profile RAM is 128 by 12, written indirectly at addresses 0 to 127.
// - I and Q outputs scaled by the profile value at coarse phase rate.
// - Control bit 15 enables the profile and clears the pointer.
// - Transmit enable high steps pointer up to programmed profile length.
// - Transmit enable low steps pointer down to zero.
// - Profile control bit 8 bypasses latency alignment of transmit enable.
// - Profile control bit 7 drops two alignment stages; pair with span 1.
// - Main control bit 14 freezes gain while profile RAM is rewritten.
// - Profile values are unsigned with 0x800 meaning unity.
`timescale 1ns/1ps
`default_nettype none
module psfgp_top #(
  parameter int ALIGN_STAGES = psfgp_pkg::ALIGN_DEPTH
) (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic [11:0]         paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                nco_sample_tick,
  input  wire logic                nco_phase_tick,
  input  wire psfgp_pkg::psfgp_iq_t fifo_sample,
  output logic                     fifo_take,
  input  wire logic                transmit_enable_in,
  output logic                     out_valid,
  output psfgp_pkg::psfgp_out_t    out_data
);

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [15:0] firc_q;
  logic [15:0] profc_q;
  logic [15:0] mainc_q;
  logic [15:0] fmt_q;
  logic [9:0]  caddr_q;
  logic [6:0]  paddr_q;
  logic [11:0] pram_q [128];

  logic [9:0]  idx;
  logic        hit;
  logic        wr;
  logic        rd_setup;
  logic [31:0] rd_d;
  logic        coef_wr;

  // ----------------------------------------
  // Sequencer and profile state
  // ----------------------------------------
  psfgp_pkg::psfgp_state_t st_q;
  logic [3:0]  tap_q;
  logic [3:0]  act_ph_q;
  logic [4:0]  phase_q;
  logic [4:0]  nphase;
  logic [4:0]  cur_phase;
  logic [3:0]  span;
  logic [7:0]  bank_base;
  logic [7:0]  coef_raddr;
  logic        start;
  logic        mac_en;
  logic        out_evt;

  logic [6:0]  ptr_q;
  logic [11:0] gain_q;
  logic        pen_q;
  logic        tx_s1_q;
  logic        tx_s2_q;
  logic [ALIGN_STAGES-1:0] tx_dly_q;
  logic        tx_eff;
  logic [6:0]  plen;
  logic        hold;

  logic signed [15:0] smp [2];
  logic signed [19:0] res [2];
  logic signed [19:0] gsat [2];
  logic signed [19:0] outq [2];
  logic        csel [2];

  // ----------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------
  assign idx      = paddr[11:2];
  assign wr       = psel && penable && pwrite && hit;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !hit;

  always_comb begin
    unique case (idx)
      psfgp_pkg::FIRC_IDX,
      psfgp_pkg::PROFC_IDX,
      psfgp_pkg::MAINC_IDX,
      psfgp_pkg::FMT_IDX,
      psfgp_pkg::CADDR_IDX,
      psfgp_pkg::CDATA_IDX,
      psfgp_pkg::PADDR_IDX,
      psfgp_pkg::PDATA_IDX,
      psfgp_pkg::STAT_IDX: hit = (paddr[1:0] == 2'h0);
      default:             hit = 1'b0;
    endcase
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (idx)
      psfgp_pkg::FIRC_IDX:  rd_d[15:0] = firc_q;
      psfgp_pkg::PROFC_IDX: rd_d[15:0] = profc_q;
      psfgp_pkg::MAINC_IDX: rd_d[15:0] = mainc_q;
      psfgp_pkg::FMT_IDX:   rd_d[15:0] = fmt_q;
      psfgp_pkg::CADDR_IDX: rd_d[9:0]  = caddr_q;
      psfgp_pkg::PADDR_IDX: rd_d[6:0]  = paddr_q;
      psfgp_pkg::PDATA_IDX: rd_d[11:0] = pram_q[paddr_q];
      psfgp_pkg::STAT_IDX:  rd_d[11:0] = {tx_eff, st_q != psfgp_pkg::PSFGP_IDLE,
                                          pen_q, 2'h0, ptr_q};
      default:              rd_d = 32'h0000_0000;
    endcase
  end

  // Captured in setup so data stands in the access phase
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= hit ? rd_d : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      firc_q  <= psfgp_pkg::CTRL_RST;
      profc_q <= psfgp_pkg::CTRL_RST;
      mainc_q <= psfgp_pkg::CTRL_RST;
      fmt_q   <= psfgp_pkg::CTRL_RST;
    end else if (wr) begin
      unique case (idx)
        psfgp_pkg::FIRC_IDX:  firc_q  <= pwdata[15:0];
        psfgp_pkg::PROFC_IDX: profc_q <= pwdata[15:0];
        psfgp_pkg::MAINC_IDX: mainc_q <= pwdata[15:0];
        psfgp_pkg::FMT_IDX:   fmt_q   <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Indirect coefficient and profile loading
  // ----------------------------------------
  assign coef_wr = wr && (idx == psfgp_pkg::CDATA_IDX);
  assign csel[0] = caddr_q[psfgp_pkg::CSEL_I_BIT];
  assign csel[1] = caddr_q[psfgp_pkg::CSEL_Q_BIT];

  // Address steps after each data write for burst loads
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      caddr_q <= psfgp_pkg::CADDR_RST;
    end else if (wr && idx == psfgp_pkg::CADDR_IDX) begin
      caddr_q <= pwdata[9:0];
    end else if (coef_wr) begin
      caddr_q[7:0] <= caddr_q[7:0] + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      paddr_q <= psfgp_pkg::PADDR_RST;
    end else if (wr && idx == psfgp_pkg::PADDR_IDX) begin
      paddr_q <= pwdata[6:0];
    end else if (wr && idx == psfgp_pkg::PDATA_IDX) begin
      paddr_q <= paddr_q + 7'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (wr && idx == psfgp_pkg::PDATA_IDX) begin
      pram_q[paddr_q] <= pwdata[11:0];
    end
  end

  // ----------------------------------------
  // Polyphase sequencer
  // ----------------------------------------
  always_comb begin
    unique case (firc_q[psfgp_pkg::IP_LSB +: 2])
      psfgp_pkg::IP_4: nphase = 5'd4;
      psfgp_pkg::IP_8: nphase = 5'd8;
      default:         nphase = 5'd16;
    endcase
  end

  assign span = firc_q[psfgp_pkg::SPAN_LSB +: 4];

  always_comb begin
    if (!firc_q[psfgp_pkg::BANK_BIT]) begin
      bank_base = 8'h00;
    end else if (nphase == 5'd16) begin
      bank_base = psfgp_pkg::BANK1_LARGE;
    end else begin
      bank_base = psfgp_pkg::BANK1_SMALL;
    end
  end

  assign coef_raddr = bank_base + {tap_q, act_ph_q};
  assign fifo_take  = nco_sample_tick;
  // A new sample restarts the phase walk at zero
  assign cur_phase  = nco_sample_tick ? 5'd0 : phase_q;
  // Ticks arriving while busy are dropped: clock must cover span plus three cycles per phase
  assign start      = nco_phase_tick && (st_q == psfgp_pkg::PSFGP_IDLE)
                      && (cur_phase < nphase);
  assign mac_en     = (st_q == psfgp_pkg::PSFGP_RUN);
  assign out_evt    = (st_q == psfgp_pkg::PSFGP_OUT);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_q <= 5'd0;
    end else if (start) begin
      phase_q <= cur_phase + 5'd1;
    end else if (nco_sample_tick) begin
      phase_q <= 5'd0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q     <= psfgp_pkg::PSFGP_IDLE;
      tap_q    <= 4'h0;
      act_ph_q <= 4'h0;
    end else begin
      unique case (st_q)
        psfgp_pkg::PSFGP_IDLE: begin
          tap_q <= 4'h0;
          if (start) begin
            st_q     <= psfgp_pkg::PSFGP_RUN;
            act_ph_q <= cur_phase[3:0];
          end
        end
        psfgp_pkg::PSFGP_RUN: begin
          tap_q <= tap_q + 4'h1;
          if (tap_q == span) begin
            st_q <= psfgp_pkg::PSFGP_OUT;
          end
        end
        psfgp_pkg::PSFGP_OUT: st_q <= psfgp_pkg::PSFGP_IDLE;
        default:              st_q <= psfgp_pkg::PSFGP_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // I and Q filter engines
  // ----------------------------------------
  assign smp[0] = fifo_sample.i;
  assign smp[1] = fifo_sample.q;

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic signed [32:0] gprod;
    logic signed [21:0] gscl;

    psfgp_mac u_mac (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .coef_we    (coef_wr && csel[c]),
      .coef_waddr (caddr_q[7:0]),
      .coef_wdata (pwdata[23:0]),
      .coef_raddr (coef_raddr),
      .float_mode (fmt_q[psfgp_pkg::FLOAT_BIT]),
      .shift_en   (nco_sample_tick),
      .shift_data (smp[c]),
      .tap_idx    (tap_q),
      .mac_en     (mac_en),
      .mac_first  (tap_q == 4'h0),
      .mac_last   (tap_q == span),
      .res_q      (res[c])
    );

    // Unsigned profile value, unity at 0x800
    assign gprod = res[c] * $signed({1'b0, gain_q});
    assign gscl  = 22'(gprod >>> psfgp_pkg::GAIN_FRAC);
    assign gsat[c] = (gscl[21:19] == {3{gscl[21]}}) ? gscl[19:0]
                   : (gscl[21] ? 20'sh80000 : 20'sh7FFFF);

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        outq[c] <= 20'sh00000;
      end else if (out_evt) begin
        outq[c] <= gsat[c];
      end
    end
  end

  assign out_data.i = outq[0];
  assign out_data.q = outq[1];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
    end else begin
      out_valid <= out_evt;
    end
  end

  // ----------------------------------------
  // Transmit enable alignment
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_s1_q <= 1'b0;
      tx_s2_q <= 1'b0;
    end else begin
      tx_s1_q <= transmit_enable_in;
      tx_s2_q <= tx_s1_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_dly_q <= '0;
    end else begin
      tx_dly_q <= {tx_dly_q[ALIGN_STAGES-2:0], tx_s2_q};
    end
  end

  always_comb begin
    if (profc_q[psfgp_pkg::BYP_BIT]) begin
      tx_eff = tx_s2_q;
    end else if (profc_q[psfgp_pkg::FAST_BIT]) begin
      tx_eff = tx_dly_q[ALIGN_STAGES-1-psfgp_pkg::ALIGN_CUT];
    end else begin
      tx_eff = tx_dly_q[ALIGN_STAGES-1];
    end
  end

  // ----------------------------------------
  // Gain profile pointer
  // ----------------------------------------
  assign plen = profc_q[psfgp_pkg::PLEN_LSB +: 7];
  assign hold = mainc_q[psfgp_pkg::HOLD_BIT];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pen_q <= 1'b0;
    end else begin
      pen_q <= firc_q[psfgp_pkg::PEN_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ptr_q <= 7'h00;
    end else if (firc_q[psfgp_pkg::PEN_BIT] && !pen_q) begin
      ptr_q <= 7'h00;
    end else if (pen_q && out_evt && !hold) begin
      if (tx_eff && ptr_q < plen) begin
        ptr_q <= ptr_q + 7'h01;
      end else if (!tx_eff && ptr_q != 7'h00) begin
        ptr_q <= ptr_q - 7'h01;
      end
      // Otherwise parked at an end until the level flips
    end
  end

  // Frozen while held so software can rewrite the RAM live
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gain_q <= psfgp_pkg::GAIN_UNITY;
    end else if (!firc_q[psfgp_pkg::PEN_BIT]) begin
      gain_q <= psfgp_pkg::GAIN_UNITY;
    end else if (out_evt && !hold) begin
      gain_q <= pram_q[ptr_q];
    end
  end

endmodule : psfgp_top
`default_nettype wire

// ==== psfgp_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module psfgp_chk (
  input wire logic                  clk,
  input wire logic                  sys_rst,
  input wire logic [11:0]           paddr,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  nco_sample_tick,
  input wire logic                  nco_phase_tick,
  input wire logic                  fifo_take,
  input wire logic                  out_valid,
  input wire psfgp_pkg::psfgp_out_t out_data
);
  // ----------------------------------------
  // Span shadow and phase tick history
  // ----------------------------------------
  logic [3:0]  span_q;
  logic [18:0] hist_q;
  always_ff @(posedge clk) begin
    if (sys_rst) span_q <= 4'h0;
    else if (psel && penable && pwrite && paddr == {psfgp_pkg::FIRC_IDX, 2'b00}) span_q <= pwdata[7:4];
  end
  always_ff @(posedge clk) begin
    if (sys_rst) hist_q <= '0;
    else hist_q <= {hist_q[17:0], nco_phase_tick};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence apb_setup_s;
    psel && !penable;
  endsequence
  sequence apb_access_s;
    psel && penable;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  chk_ready_access: assert property (apb_setup_s ##1 apb_access_s |-> pready)
    else $error("access phase without ready");
  chk_err_align: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  chk_err_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("error outside access phase");
  chk_bad_read: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  chk_take_tick: assert property (fifo_take == nco_sample_tick)
    else $error("pop not tied to sample tick");
  chk_valid_pulse: assert property (out_valid |=> !out_valid)
    else $error("output valid longer than a cycle");
  chk_data_hold: assert property (!out_valid |-> out_data == $past(out_data))
    else $error("output changed without valid");
  chk_out_latency: assert property (out_valid |-> hist_q[{1'b0, span_q} + 5'd2])
    else $error("output not span plus three after tick");
endmodule : psfgp_chk
bind psfgp_top psfgp_chk u_chk (.clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
  .pready, .pslverr, .nco_sample_tick, .nco_phase_tick, .fifo_take, .out_valid, .out_data);
`default_nettype wire

// ==== psfgp_src.sv ====
`timescale 1ns/1ps
`default_nettype none
module psfgp_src (
  input wire logic              clk,
  output logic                  nco_sample_tick,
  output psfgp_pkg::psfgp_iq_t  fifo_sample,
  output logic                  nco_phase_tick
);
  initial begin
    nco_sample_tick = 1'b0;
    nco_phase_tick = 1'b0;
    fifo_sample = 32'h0;
  end
  // ----------------------------------------
  // One coarse phase tick, optionally with a new sample
  // ----------------------------------------
  // Head word inverted between pops so a stale read never matches
  task automatic send(input logic ws, input psfgp_pkg::psfgp_iq_t s);
    @(posedge clk);
    nco_sample_tick <= ws;
    nco_phase_tick <= 1'b1;
    fifo_sample <= s;
    @(posedge clk);
    nco_sample_tick <= 1'b0;
    nco_phase_tick <= 1'b0;
    fifo_sample <= ~s;
  endtask : send
endmodule : psfgp_src
`default_nettype wire

// ==== tb_psfgp_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_psfgp_top;
  typedef struct packed {
    logic [9:0]            caddr;
    logic [23:0]           word;
    logic [15:0]           firc;
    logic [15:0]           fmt;
    psfgp_pkg::psfgp_iq_t  s;
    psfgp_pkg::psfgp_out_t e;
  } psfgp_row_t;
  logic                  clk = 1'b0;
  logic                  sys_rst = 1'b1;
  logic [11:0]           paddr = 12'h000;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [31:0]           pwdata = 32'h0;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  nco_sample_tick;
  logic                  nco_phase_tick;
  psfgp_pkg::psfgp_iq_t  fifo_sample;
  logic                  fifo_take;
  logic                  transmit_enable_in = 1'b0;
  logic                  out_valid;
  psfgp_pkg::psfgp_out_t out_data;
  psfgp_pkg::psfgp_out_t o;
  logic [31:0]           rdat;
  logic                  rerr;
  int                    fails = 0;
  int                    samples_checked = 0;
  always #2.5 clk = ~clk;
  psfgp_src u_src (.clk, .nco_sample_tick, .fifo_sample, .nco_phase_tick);
  psfgp_top DUT (.clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .nco_sample_tick, .nco_phase_tick, .fifo_sample, .fifo_take, .transmit_enable_in, .out_valid, .out_data);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      fails++;
      stop_test();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    apb(1'b1, {i, 2'b00}, d);
  endtask : wr
  task automatic rd(input logic [9:0] i);
    apb(1'b0, {i, 2'b00}, 32'h0);
  endtask : rd
  task automatic phase(input logic ws, input psfgp_pkg::psfgp_iq_t s);
    int n;
    u_src.send(ws, s);
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      #1;
      if (out_valid === 1'b1) break;
    end
    if (n == 40) begin
      fails++;
      stop_test();
    end
    o = out_data;
  endtask : phase
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    stop_test();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    psfgp_row_t rows [7];
    int         i;
    int         n;
    logic [19:0] e;
    rows = '{'{10'h300, 24'h004000, 16'h0030, 16'h0000, 32'h4000_2000, 40'h20000_10000},
             '{10'h100, 24'h002000, 16'h0030, 16'h0000, 32'h4000_4000, 40'h10000_20000},
             '{10'h308, 24'h001000, 16'h0130, 16'h0000, 32'h4000_4000, 40'h08000_08000},
             '{10'h308, 24'h001000, 16'h0131, 16'h0000, 32'h2000_2000, 40'h04000_04000},
             '{10'h380, 24'h000800, 16'h0132, 16'h0000, 32'h2000_2000, 40'h02000_02000},
             '{10'h300, 24'h400001, 16'h0033, 16'h1000, 32'h4000_4000, 40'h10000_10000},
             '{10'h300, 24'h400002, 16'h0030, 16'h1000, 32'h4000_C000, 40'h08000_F8000}};
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(psfgp_pkg::FIRC_IDX);
    check("filter control reset", 40'(rdat), 40'h0);
    rd(psfgp_pkg::FMT_IDX);
    check("format reset", 40'(rdat), 40'h0);
    wr(psfgp_pkg::CADDR_IDX, 32'h300);
    for (i = 0; i < 256; i++) wr(psfgp_pkg::CDATA_IDX, 32'h0);
    for (i = 0; i < 7; i++) begin
      wr(psfgp_pkg::CADDR_IDX, 32'(rows[i].caddr));
      wr(psfgp_pkg::CDATA_IDX, 32'(rows[i].word));
      wr(psfgp_pkg::FIRC_IDX, 32'(rows[i].firc));
      wr(psfgp_pkg::FMT_IDX, 32'(rows[i].fmt));
      phase(1'b1, rows[i].s);
      check("row output", o, rows[i].e);
    end
    $display("coefficient rows done");
    wr(psfgp_pkg::FMT_IDX, 32'h0);
    wr(psfgp_pkg::FIRC_IDX, 32'h0030);
    wr(psfgp_pkg::CADDR_IDX, 32'h300);
    for (i = 0; i < 4; i++) wr(psfgp_pkg::CDATA_IDX, 32'h1000 * (i + 1));
    for (i = 0; i < 4; i++) begin
      phase(i == 0, 32'h4000_4000);
      e = 20'(32'h8000 * (i + 1));
      check("phase output", o, {e, e});
    end
    u_src.send(1'b0, 32'h4000_4000);
    n = 0;
    repeat (30) begin
      @(posedge clk);
      #1;
      if (out_valid === 1'b1) n++;
    end
    check("extra phase outputs", 40'(n), 40'h0);
    $display("phase order done");
    wr(psfgp_pkg::PADDR_IDX, 32'h0);
    for (i = 0; i < 128; i++) wr(psfgp_pkg::PDATA_IDX, 32'h400);
    wr(psfgp_pkg::PADDR_IDX, 32'h7F);
    rd(psfgp_pkg::PDATA_IDX);
    check("profile word", 40'(rdat), 40'h400);
    wr(psfgp_pkg::PROFC_IDX, 32'h103);
    wr(psfgp_pkg::FIRC_IDX, 32'h8030);
    transmit_enable_in <= 1'b1;
    repeat (10) @(posedge clk);
    for (i = 0; i < 6; i++) phase(1'b1, 32'h4000_4000);
    check("ramped output", o, 40'h04000_04000);
    rd(psfgp_pkg::STAT_IDX);
    check("pointer at length", 40'(rdat[6:0]), 40'h3);
    wr(psfgp_pkg::MAINC_IDX, 32'h4000);
    wr(psfgp_pkg::PADDR_IDX, 32'h0);
    for (i = 0; i < 4; i++) wr(psfgp_pkg::PDATA_IDX, 32'h200);
    transmit_enable_in <= 1'b0;
    repeat (10) @(posedge clk);
    for (i = 0; i < 4; i++) phase(1'b1, 32'h4000_4000);
    check("held output", o, 40'h04000_04000);
    rd(psfgp_pkg::STAT_IDX);
    check("held pointer", 40'(rdat[6:0]), 40'h3);
    wr(psfgp_pkg::MAINC_IDX, 32'h0);
    for (i = 0; i < 6; i++) phase(1'b1, 32'h4000_4000);
    check("ramped down output", o, 40'h02000_02000);
    rd(psfgp_pkg::STAT_IDX);
    check("pointer at zero", 40'(rdat[6:0]), 40'h0);
    transmit_enable_in <= 1'b1;
    repeat (10) @(posedge clk);
    for (i = 0; i < 2; i++) phase(1'b1, 32'h4000_4000);
    wr(psfgp_pkg::FIRC_IDX, 32'h0030);
    wr(psfgp_pkg::FIRC_IDX, 32'h8030);
    rd(psfgp_pkg::STAT_IDX);
    check("pointer cleared", 40'(rdat[6:0]), 40'h0);
    $display("gain profile done");
    wr(psfgp_pkg::FIRC_IDX, 32'h0030);
    for (i = 0; i < 4; i++) begin
      wr(psfgp_pkg::CADDR_IDX, 32'h300 + 32'(16 * i));
      wr(psfgp_pkg::CDATA_IDX, 32'h7FFF);
    end
    for (i = 0; i < 4; i++) phase(1'b1, 32'h7FFF_8001);
    check("clipped output", o, 40'h7FFFF_80000);
    apb(1'b0, 12'h3FC, 32'h0);
    check("unmapped read", 40'({rerr, rdat}), 40'h1_0000_0000);
    apb(1'b1, 12'h036, 32'hFFFF);
    check("misaligned write error", 40'(rerr), 40'h1);
    apb(1'b0, 12'h035, 32'h0);
    check("misaligned read", 40'({rerr, rdat}), 40'h1_0000_0000);
    rd(psfgp_pkg::FIRC_IDX);
    check("misaligned write", 40'({rerr, rdat}), 40'h30);
    // Short alignment path sees the pin two cycles sooner
    wr(psfgp_pkg::FIRC_IDX, 32'h0020);
    for (i = 0; i < 2; i++) begin
      transmit_enable_in <= 1'b0;
      wr(psfgp_pkg::PROFC_IDX, 32'h003 | 32'(i << 7));
      repeat (10) @(posedge clk);
      transmit_enable_in <= 1'b1;
      rd(psfgp_pkg::STAT_IDX);
      rd(psfgp_pkg::STAT_IDX);
      check("aligned enable", 40'(rdat[11]), 40'(i));
    end
    $display("saturation and refusals done");
    stop_test();
  end
endmodule : tb_psfgp_top
`default_nettype wire
